// File: src/ust_sync_tx.sv
// Synchronous master transmit path with an AXI4-Lite register slave and a word buffer.
// Assumes one clock core_clk; the data pin is two-way and resolved outside.
`timescale 1ns/1ps
`include "ust_params.svh"

// Plain synchronous FIFO with valid/ready on both sides
module ust_fifo
  import ust_pkg::*;
#(
  parameter int WIDTH = `UST_WORD_W,
  parameter int DEPTH = `UST_FIFO_DEPTH,
  parameter int AW = `UST_FIFO_AW
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Full when the pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage is written without reset; only valid entries are ever read
  always_ff @(posedge core_clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // ust_fifo

module ust_sync_tx
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`UST_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`UST_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sync_clock_line,
  output logic sync_clock_line_oe,
  input wire logic sync_data_line_in,
  output logic sync_data_line_out,
  output logic sync_data_line_oe
);
  ust_cfg_t cfg;
  logic transmit_ninth_bit;
  logic transmit_interrupt_enable;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [7:0] last_buffer_write;
  ust_state_t state;
  logic [8:0] transmit_shift_register;
  logic word_nine;
  logic [3:0] bit_idx;
  logic [15:0] half_cnt;
  logic phase;
  logic aw_held;
  logic w_held;
  logic [`UST_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic line_meta;
  logic line_sync;
  logic master_on;
  logic [15:0] divisor;
  logic half_end;
  logic last_bit;
  logic load_word;
  logic buf_in_valid;
  logic buf_in_ready;
  ust_word_t buf_in;
  ust_word_t buf_out;
  logic buf_out_valid;
  logic do_write;
  logic wr_is_buf;
  logic [31:0] next_rdata;

  // Index of a decoded register, 4'hF for an unmapped address
  function automatic logic [3:0] reg_sel(input logic [`UST_ADDR_W-1:0] a);
    if (a == `UST_OFF_TX_CTRL) reg_sel = 4'h0;
    else if (a == `UST_OFF_RX_CTRL) reg_sel = 4'h1;
    else if (a == `UST_OFF_BAUD_CTRL) reg_sel = 4'h2;
    else if (a == `UST_OFF_DIV_LOW) reg_sel = 4'h3;
    else if (a == `UST_OFF_DIV_HIGH) reg_sel = 4'h4;
    else if (a == `UST_OFF_TX_BUF) reg_sel = 4'h5;
    else if (a == `UST_OFF_FLAGS) reg_sel = 4'h6;
    else if (a == `UST_OFF_ENABLES) reg_sel = 4'h7;
    else reg_sel = 4'hF;
  endfunction

  // Master transmit needs all four mode bits
  assign master_on = cfg.clock_source_select && cfg.sync_select
    && cfg.serial_port_enable && cfg.transmit_enable;
  assign divisor = cfg.wide_baud_generator_select ? {baud_divisor_high, baud_divisor_low}
    : {8'h00, baud_divisor_low};
  assign half_end = (half_cnt == divisor);
  assign last_bit = (bit_idx == (word_nine ? 4'h8 : 4'h7));
  // A waiting word is taken in idle, or at the end of the last bit
  assign load_word = master_on && buf_out_valid
    && ((state == UST_IDLE) || (half_end && phase && last_bit));

  // Write path: address and data latched in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_is_buf = (reg_sel(aw_addr) == 4'h5);
  // A buffer write waits while the buffer is full, stalling the bus
  assign do_write = aw_held && w_held && !s_axi_bvalid && (!wr_is_buf || buf_in_ready);
  assign buf_in_valid = do_write && wr_is_buf && w_strb[0];
  assign buf_in.ninth = transmit_ninth_bit;
  assign buf_in.data = w_data[7:0];

  ust_fifo #(
    .WIDTH(`UST_WORD_W),
    .DEPTH(`UST_FIFO_DEPTH),
    .AW(`UST_FIFO_AW)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(buf_in),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(buf_out_valid),
    .out_ready(load_word)
  );

  // Latch write address and data
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UST_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (reg_sel(aw_addr) == 4'hF) ? `UST_RESP_SLVERR : `UST_RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; flag and empty bits have no write path
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= '0;
      transmit_ninth_bit <= 1'b0;
      transmit_interrupt_enable <= 1'b0;
      baud_divisor_low <= `UST_REG_RESET;
      baud_divisor_high <= `UST_REG_RESET;
      last_buffer_write <= `UST_REG_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      if (reg_sel(aw_addr) == 4'h0)
      begin
        cfg.clock_source_select <= w_data[`UST_TXC_CLK_SRC];
        cfg.nine_bit_transmit_select <= w_data[`UST_TXC_NINE];
        cfg.transmit_enable <= w_data[`UST_TXC_TX_EN];
        cfg.sync_select <= w_data[`UST_TXC_SYNC];
        transmit_ninth_bit <= w_data[`UST_TXC_NINTH];
      end
      else if (reg_sel(aw_addr) == 4'h1)
      begin
        cfg.serial_port_enable <= w_data[`UST_RXC_PORT_EN];
      end
      else if (reg_sel(aw_addr) == 4'h2)
      begin
        cfg.clock_idle_polarity <= w_data[`UST_BC_IDLE_POL];
        cfg.wide_baud_generator_select <= w_data[`UST_BC_WIDE];
      end
      else if (reg_sel(aw_addr) == 4'h3)
      begin
        baud_divisor_low <= w_data[7:0];
      end
      else if (reg_sel(aw_addr) == 4'h4)
      begin
        baud_divisor_high <= w_data[7:0];
      end
      else if (reg_sel(aw_addr) == 4'h5)
      begin
        last_buffer_write <= w_data[7:0];
      end
      else if (reg_sel(aw_addr) == 4'h7)
      begin
        transmit_interrupt_enable <= w_data[`UST_PE_TX_IE];
      end
    end
  end

  // Read mux; the shift register itself has no address
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_sel(s_axi_araddr) == 4'h0)
    begin
      next_rdata[`UST_TXC_CLK_SRC] = cfg.clock_source_select;
      next_rdata[`UST_TXC_NINE] = cfg.nine_bit_transmit_select;
      next_rdata[`UST_TXC_TX_EN] = cfg.transmit_enable;
      next_rdata[`UST_TXC_SYNC] = cfg.sync_select;
      next_rdata[`UST_TXC_SR_EMPTY] = (state == UST_IDLE);
      next_rdata[`UST_TXC_NINTH] = transmit_ninth_bit;
    end
    else if (reg_sel(s_axi_araddr) == 4'h1)
    begin
      next_rdata[`UST_RXC_PORT_EN] = cfg.serial_port_enable;
      next_rdata[`UST_RXC_LINE] = line_sync && (state == UST_IDLE);
    end
    else if (reg_sel(s_axi_araddr) == 4'h2)
    begin
      next_rdata[`UST_BC_IDLE_POL] = cfg.clock_idle_polarity;
      next_rdata[`UST_BC_WIDE] = cfg.wide_baud_generator_select;
    end
    else if (reg_sel(s_axi_araddr) == 4'h3)
    begin
      next_rdata[7:0] = baud_divisor_low;
    end
    else if (reg_sel(s_axi_araddr) == 4'h4)
    begin
      next_rdata[7:0] = baud_divisor_high;
    end
    else if (reg_sel(s_axi_araddr) == 4'h5)
    begin
      next_rdata[7:0] = last_buffer_write;
    end
    else if (reg_sel(s_axi_araddr) == 4'h6)
    begin
      // Empty flag tracks the buffer, independent of the enable
      next_rdata[`UST_PF_BUF_EMPTY] = !buf_out_valid;
    end
    else if (reg_sel(s_axi_araddr) == 4'h7)
    begin
      next_rdata[`UST_PE_TX_IE] = transmit_interrupt_enable;
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UST_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (reg_sel(s_axi_araddr) == 4'hF) ? `UST_RESP_SLVERR : `UST_RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two-flop synchroniser on the data pin
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
    end
    else
    begin
      line_meta <= sync_data_line_in;
      line_sync <= line_meta;
    end
  end

  // Shifter: each bit is two half periods of divisor+1 cycles
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= UST_IDLE;
      transmit_shift_register <= 9'h000;
      word_nine <= 1'b0;
      bit_idx <= 4'h0;
      half_cnt <= 16'h0000;
      phase <= 1'b0;
    end
    else
    begin
      case (state)
        UST_IDLE:
        begin
          half_cnt <= 16'h0000;
          phase <= 1'b0;
          if (load_word)
          begin
            transmit_shift_register <= buf_out;
            word_nine <= cfg.nine_bit_transmit_select;
            bit_idx <= 4'h0;
            state <= UST_SHIFT;
          end
        end
        UST_SHIFT:
        begin
          if (!master_on)
          begin
            // Dropping an enable aborts the word in flight
            state <= UST_IDLE;
          end
          else if (!half_end)
          begin
            half_cnt <= half_cnt + 16'h0001;
          end
          else
          begin
            half_cnt <= 16'h0000;
            phase <= !phase;
            if (phase && last_bit)
            begin
              if (load_word)
              begin
                transmit_shift_register <= buf_out;
                word_nine <= cfg.nine_bit_transmit_select;
                bit_idx <= 4'h0;
              end
              else
              begin
                state <= UST_IDLE;
              end
            end
            else if (phase)
            begin
              transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        default:
        begin
          state <= UST_IDLE;
        end
      endcase
    end
  end

  // Clock leaves idle level in the second half of each bit
  assign sync_clock_line = cfg.clock_idle_polarity ^ ((state == UST_SHIFT) && phase);
  assign sync_clock_line_oe = cfg.serial_port_enable && cfg.clock_source_select;
  assign sync_data_line_out = (state == UST_SHIFT) ? transmit_shift_register[0] : 1'b0;
  // Data pin driven only while shifting, so reception and transmission never overlap
  assign sync_data_line_oe = cfg.serial_port_enable && (state == UST_SHIFT);
endmodule // ust_sync_tx

// File: inc/ust_params.svh
// Offsets, field positions, reset values and sizes of the synchronous transmitter.
// Assumes a 32-bit AXI4-Lite register bus with one register to each aligned word.
`ifndef UST_PARAMS_SVH
`define UST_PARAMS_SVH
`define UST_ADDR_W 5
`define UST_OFF_TX_CTRL 5'h00
`define UST_OFF_RX_CTRL 5'h04
`define UST_OFF_BAUD_CTRL 5'h08
`define UST_OFF_DIV_LOW 5'h0C
`define UST_OFF_DIV_HIGH 5'h10
`define UST_OFF_TX_BUF 5'h14
`define UST_OFF_FLAGS 5'h18
`define UST_OFF_ENABLES 5'h1C
`define UST_TXC_CLK_SRC 7
`define UST_TXC_NINE 6
`define UST_TXC_TX_EN 5
`define UST_TXC_SYNC 4
`define UST_TXC_SR_EMPTY 1
`define UST_TXC_NINTH 0
`define UST_RXC_PORT_EN 7
`define UST_RXC_LINE 0
`define UST_BC_IDLE_POL 4
`define UST_BC_WIDE 3
`define UST_PF_BUF_EMPTY 4
`define UST_PE_TX_IE 4
`define UST_REG_RESET 8'h00
`define UST_FIFO_DEPTH 16
`define UST_FIFO_AW 4
`define UST_WORD_W 9
`define UST_RESP_OKAY 2'h0
`define UST_RESP_SLVERR 2'h2
`endif

// File: inc/ust_pkg.sv
// Types shared by the synchronous transmitter and its buffer.
// Assumes ust_params.svh is on the include path.
`include "ust_params.svh"
package ust_pkg;
  // One queued word: ninth bit above eight data bits
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } ust_word_t;

  // Mode bits that steer the shifter
  typedef struct packed {
    logic clock_source_select;
    logic sync_select;
    logic serial_port_enable;
    logic transmit_enable;
    logic nine_bit_transmit_select;
    logic wide_baud_generator_select;
    logic clock_idle_polarity;
  } ust_cfg_t;

  typedef enum logic [1:0] {
    UST_IDLE = 2'b01,
    UST_SHIFT = 2'b10
  } ust_state_t;
endpackage

// File: sim/ust_sync_tx_sva.sv
// Checker for bus handshakes and line timing of the transmitter, bound to its top module.
// Assumes one clock domain and the designer's one-cycle register bus answers.
`timescale 1ns/1ps
module ust_sync_tx_sva
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sync_clock_line,
  input wire logic sync_clock_line_oe,
  input wire logic sync_data_line_out,
  input wire logic sync_data_line_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Line checks
  data_master_a: assert property (sync_data_line_oe |-> sync_clock_line_oe)
    else $error("data driven without master clock");
  data_rest_a: assert property (!sync_data_line_oe |-> !sync_data_line_out)
    else $error("released data output not low");
  bit_edge_a: assert property (sync_data_line_oe && $past(sync_data_line_oe)
    && $changed(sync_data_line_out) |-> $changed(sync_clock_line))
    else $error("data changed away from a bit boundary");
  load_idle_a: assert property ($rose(sync_data_line_oe) |-> $stable(sync_clock_line))
    else $error("word started with clock off idle");
  idle_return_a: assert property ($fell(sync_data_line_oe) |-> $changed(sync_clock_line))
    else $error("clock did not return to idle at word end");
  word_len_a: assert property ($rose(sync_data_line_oe) |-> sync_data_line_oe [*8])
    else $error("word shorter than its bits");
  // Bus checks; a full buffer may stall the answer
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:200] s_axi_bvalid)
    else $error("write not answered");
  aw_held_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answered without both channels held");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");

  word_c: cover property ($rose(sync_data_line_oe));
  stall_c: cover property (s_axi_awvalid && !s_axi_awready);
  edge_c: cover property (sync_data_line_oe && $changed(sync_data_line_out));
endmodule // ust_sync_tx_sva

// File: sim/ust_slave_model.sv
// Slave on the shift clock and data lines; samples data on the mid-bit clock edge.
// Assumes the bench resolves the data wire and gives the idle level and word size.
`timescale 1ns/1ps
module ust_slave_model
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_line,
  input wire logic data_line,
  input wire logic idle_pol,
  input wire logic nine,
  output ust_word_t word,
  output logic [7:0] n_words
);
  logic clk_q;
  logic [8:0] sr;
  logic [3:0] n_bits;

  // Leaving idle marks mid-bit, well clear of data changes at bit start
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_q <= 1'b0;
      sr <= 9'h000;
      n_bits <= 4'h0;
      word <= '0;
      n_words <= 8'h00;
    end
    else
    begin
      clk_q <= clk_line;
      if (clk_q == idle_pol && clk_line != idle_pol)
      begin
        sr <= {data_line, sr[8:1]};
        if (n_bits == (nine ? 4'h8 : 4'h7))
        begin
          n_bits <= 4'h0;
          n_words <= n_words + 8'h01;
          word <= nine ? {data_line, sr[8:1]} : {1'b0, data_line, sr[8:2]};
        end
        else
          n_bits <= n_bits + 4'h1;
      end
    end
  end
endmodule // ust_slave_model

// File: sim/tb_ust_sync_tx.sv
// Self-checking bench: register bus tasks, a slave model on the lines, one task per scenario.
// Assumes package, design, slave model and checker are compiled before it.
`timescale 1ns/1ps
`include "ust_params.svh"
module tb_ust_sync_tx;
  logic core_clk, rst_n, line_drv, nine, idle_pol, data_wire, oe_q;
  logic [`UST_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sync_clock_line, sync_clock_line_oe, sync_data_line_out, sync_data_line_oe;
  logic [7:0] rx_count, seen_n;
  ust_pkg::ust_word_t rx_word;
  ust_pkg::ust_word_t got[$];
  int n_mismatch, check_count, oe_cycles, oe_starts;

  // Released line shows the level the bench drives in the slave's place
  assign data_wire = sync_data_line_oe ? sync_data_line_out : line_drv;

  ust_sync_tx dut
  (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_clock_line,
    .sync_clock_line_oe, .sync_data_line_in(data_wire), .sync_data_line_out,
    .sync_data_line_oe
  );
  ust_slave_model slave
  (
    .core_clk, .rst_n, .clk_line(sync_clock_line), .data_line(data_wire), .idle_pol,
    .nine, .word(rx_word), .n_words(rx_count)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Log finished words and line activity at each edge
  always @(posedge core_clk)
  begin
    if (rx_count != seen_n)
      got.push_back(rx_word);
    seen_n <= rx_count;
    if (sync_data_line_oe)
      oe_cycles++;
    if (sync_data_line_oe && !oe_q)
      oe_starts++;
    oe_q = sync_data_line_oe;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Each channel is held until its own ready; the answer ends the task
  task automatic wrc(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    // Ready stays high between calls so no signal is driven twice in one step
    check(s_axi_bresp, `UST_RESP_OKAY, "bresp");
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string what);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    check(s_axi_rresp, `UST_RESP_OKAY, "rresp");
    check(s_axi_rdata, e, what);
  endtask

  task automatic settle;
    while (sync_data_line_oe)
      @(posedge core_clk);
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    rdc(`UST_OFF_TX_CTRL, 32'h02, "tx_ctrl_rst");
    rdc(`UST_OFF_FLAGS, 32'h10, "flags_rst");
    wrc(`UST_OFF_ENABLES, 32'h10);
    rdc(`UST_OFF_FLAGS, 32'h10, "flags_ie");
    check(sync_clock_line_oe, 1'b0, "clk_oe_rst");
  endtask

  task automatic t_enable;
    int s;
    s = got.size();
    for (int p = 0; p < 2; p++)
    begin
      idle_pol <= p[0];
      wrc(`UST_OFF_BAUD_CTRL, p << 4);
      wrc(`UST_OFF_RX_CTRL, 32'h00);
      wrc(`UST_OFF_TX_CTRL, 32'h80);
      @(posedge core_clk);
      check(sync_clock_line_oe, 1'b0, "clk_oe_off");
      wrc(`UST_OFF_RX_CTRL, 32'h80);
      @(posedge core_clk);
      check(sync_clock_line_oe, 1'b1, "clk_oe_on");
      check(sync_clock_line, p[0], "clk_idle");
    end
    wrc(`UST_OFF_TX_CTRL, 32'hA0);
    wrc(`UST_OFF_TX_BUF, 32'h66);
    repeat (40) @(posedge core_clk);
    check(got.size() - s + sync_data_line_oe, 0, "no_sync");
    wrc(`UST_OFF_TX_CTRL, 32'hB0);
    while (got.size() == s)
      @(posedge core_clk);
    check(got[s], 32'h066, "held_word");
  endtask

  // One word with the port enabled; h is the half bit in cycles
  task automatic send(input logic [8:0] w, input int bits, input int h);
    int c, s;
    settle();
    c = oe_cycles;
    s = got.size();
    nine <= bits == 9;
    wrc(`UST_OFF_TX_CTRL, 32'hB0 | (bits - 8) << 6 | w[8]);
    wrc(`UST_OFF_TX_BUF, w[7:0]);
    while (got.size() == s)
      @(posedge core_clk);
    settle();
    check(oe_cycles - c, 2 * h * bits, "word_cycles");
    check(got[s], bits == 9 ? w : {1'b0, w[7:0]}, "word");
    rdc(`UST_OFF_TX_CTRL, 32'hB2 | (bits - 8) << 6 | w[8], "tx_ctrl");
    rdc(`UST_OFF_FLAGS, 32'h10, "flags");
  endtask

  task automatic t_modes;
    for (int p = 0; p < 2; p++)
    begin
      idle_pol <= p[0];
      wrc(`UST_OFF_BAUD_CTRL, p << 4);
      send(9'h1A5, 8, 1);
      send(9'h15A, 9, 1);
    end
  endtask

  task automatic t_baud;
    idle_pol <= 1'b0;
    wrc(`UST_OFF_BAUD_CTRL, 32'h00);
    wrc(`UST_OFF_DIV_HIGH, 32'h01);
    wrc(`UST_OFF_DIV_LOW, 32'h02);
    send(9'h0C3, 8, 3);
    wrc(`UST_OFF_BAUD_CTRL, 32'h08);
    send(9'h03C, 8, 259);
    wrc(`UST_OFF_BAUD_CTRL, 32'h00);
    wrc(`UST_OFF_DIV_LOW, 32'h01);
  endtask

  // More words than the buffer holds, so writes stall while the line runs
  task automatic t_burst;
    int s, st;
    settle();
    s = got.size();
    st = oe_starts;
    nine <= 1'b0;
    wrc(`UST_OFF_TX_CTRL, 32'hB0);
    rdc(`UST_OFF_RX_CTRL, 32'h81, "rx_idle");
    for (int i = 0; i < 24; i++)
    begin
      wrc(`UST_OFF_TX_BUF, 32'h40 + i);
      if (i == 2)
        rdc(`UST_OFF_FLAGS, 32'h00, "flags_busy");
      if (i == 3)
        rdc(`UST_OFF_RX_CTRL, 32'h80, "rx_busy");
    end
    rdc(`UST_OFF_TX_BUF, 32'h57, "tx_buf");
    while (got.size() < s + 24)
      @(posedge core_clk);
    settle();
    check(oe_starts - st, 1, "gaps");
    for (int i = 0; i < 24; i++)
      check(got[s + i], 32'h40 + i, "burst");
    wrc(`UST_OFF_FLAGS, 32'h00);
    rdc(`UST_OFF_FLAGS, 32'h10, "flag_clear");
  endtask

  initial
  begin
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {nine, idle_pol, seen_n, oe_q} = '0;
    line_drv = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_enable();
    t_modes();
    t_baud();
    t_burst();
    close_out();
  end

  // Watchdog well beyond the longest run of about 5400 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end
endmodule // tb_ust_sync_tx

bind ust_sync_tx ust_sync_tx_sva sva
(
  .core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sync_clock_line,
  .sync_clock_line_oe, .sync_data_line_out, .sync_data_line_oe
);
